/* verilog/dvdlp_map.vh */
// constants for the loader data port: timing counts and shared pin positions
// assumes a 100 MHz core clock
`ifndef DVDLP_MAP_VH
`define DVDLP_MAP_VH

`define DVDLP_CLK_MHZ       100
// control port clock half period, least time
`define DVDLP_CTL_HALF_NS   500
`define DVDLP_CTL_HALF_CYC  ((`DVDLP_CTL_HALF_NS * `DVDLP_CLK_MHZ + 999) / 1000)
// host master strobe least width
`define DVDLP_HM_STB_NS     60
`define DVDLP_HM_STB_CYC    ((`DVDLP_HM_STB_NS * `DVDLP_CLK_MHZ + 999) / 1000)

// shared data pin positions in I/O channel mode
`define DVDLP_PIN_CD_SERIAL_IN   15
`define DVDLP_PIN_CD_CHANNEL_CLK   14
`define DVDLP_PIN_CD_BIT_CLK   13
`define DVDLP_PIN_CD_ERR    12
`define DVDLP_PIN_CTL_DI    11
`define DVDLP_PIN_CTL_DO    10
`define DVDLP_PIN_CTL_RDY   9
`define DVDLP_PIN_CTL_CK    8
// shared chip-select pin positions in I/O channel mode
`define DVDLP_PIN_SOS       0
`define DVDLP_PIN_ERR       1
// chip-select output enables while the I/O channel owns pins
`define DVDLP_CS_OE_IOCH    4'hC

`endif

/* verilog/dvdlp_ser_rx.v */
// four-wire serial sector data capture
// assumes all four loader inputs are asynchronous to CLK
`timescale 1ns/100ps

module dvdlp_ser_rx #(
  parameter BYTE_W = 8,
  parameter CNT_W  = 4
) (
  input  wire              clk,
  input  wire              rst_b,
  input  wire              ce,
  input  wire              msb_first,
  input  wire              lclk,
  input  wire              lbit,
  input  wire              lvalid,
  input  wire              lsos,
  output reg  [BYTE_W-1:0] byte_out,
  output reg               byte_valid,
  output reg               byte_sos,
  output reg               sos_event
);

  function [BYTE_W-1:0] shift_in;
    input [BYTE_W-1:0] sh;
    input              b;
    input              msb;
    begin
      shift_in = msb ? {sh[BYTE_W-2:0], b} : {b, sh[BYTE_W-1:1]};
    end
  endfunction

  reg  [3:0]        meta_r;
  reg  [3:0]        sync_r;
  reg               clk_d_r;
  reg  [BYTE_W-1:0] sh_r;
  reg  [CNT_W-1:0]  cnt_r;
  reg               pend_r;
  wire              s_clk   = sync_r[0];
  wire              s_bit   = sync_r[1];
  wire              s_vld   = sync_r[2];
  wire              s_sos   = sync_r[3];
  wire              rise    = s_clk & ~clk_d_r;
  wire [BYTE_W-1:0] base    = s_sos ? {BYTE_W{1'b0}} : sh_r;
  wire [CNT_W-1:0]  cbase   = s_sos ? {CNT_W{1'b0}} : cnt_r;
  wire [BYTE_W-1:0] sh_nxt  = shift_in(base, s_bit, msb_first);
  wire [CNT_W-1:0]  cnt_nxt = cbase + {{(CNT_W-1){1'b0}}, 1'b1};

  //////////////////////////////////////////////////////////////////////////
  // loader clock domain crossing: two stages, then edge detect on stage two
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r  <= 4'h0;
      sync_r  <= 4'h0;
      clk_d_r <= 1'b0;
    end else if (ce) begin
      meta_r  <= {lsos, lvalid, lbit, lclk};
      sync_r  <= meta_r;
      clk_d_r <= sync_r[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data is sampled at the same sync depth as the clock edge it belongs to
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_r       <= {BYTE_W{1'b0}};
      cnt_r      <= {CNT_W{1'b0}};
      pend_r     <= 1'b0;
      byte_out   <= {BYTE_W{1'b0}};
      byte_valid <= 1'b0;
      byte_sos   <= 1'b0;
      sos_event  <= 1'b0;
    end else if (ce) begin
      byte_valid <= 1'b0;
      sos_event  <= 1'b0;
      if (rise) begin
        if (s_sos) begin
          sos_event <= 1'b1;
          pend_r    <= 1'b1;
          cnt_r     <= {CNT_W{1'b0}};
        end
        if (s_vld) begin
          sh_r <= sh_nxt;
          if (cnt_nxt == BYTE_W[CNT_W-1:0]) begin
            byte_out   <= sh_nxt;
            byte_valid <= 1'b1;
            byte_sos   <= pend_r | s_sos;
            pend_r     <= 1'b0;
            cnt_r      <= {CNT_W{1'b0}};
          end else begin
            cnt_r <= cnt_nxt;
          end
        end
      end
    end
  end

endmodule

/* verilog/dvdlp_top.v */
// loader data port: serial sector input, I/O channel on the shared host pins,
// CD serial input, loader control port and the host master it displaces
// assumes pin inputs are asynchronous; user-side inputs are on CLK
`timescale 1ns/100ps
`include "dvdlp_map.vh"

module dvdlp_top #(
  parameter CD_W     = 16,
  parameter CTL_BITS = 8
) (
  input  wire            CLK,
  input  wire            RST_B,
  input  wire            CE,
  input  wire            IOCH_MODE,
  input  wire            SER_MSB_FIRST,
  input  wire            SER_LOADER_CLK,
  input  wire            SER_LOADER_BIT_IN,
  input  wire            SER_LOADER_BIT_VALID,
  input  wire            SER_SECTOR_START,
  output wire [7:0]      SER_BYTE,
  output wire            SER_BYTE_VALID,
  output wire            SER_BYTE_SOS,
  output wire            SER_SOS_EVENT,
  output wire            SHR_RD_O,
  input  wire            SHR_WR_I,
  output wire            SHR_WR_O,
  output wire            SHR_WR_OE,
  input  wire            SHR_RDY_I,
  input  wire [1:0]      SHR_CS_I,
  output wire [3:0]      SHR_CS_O,
  output wire [3:0]      SHR_CS_OE,
  output wire [2:0]      SHR_A_O,
  input  wire [15:0]     SHR_D_I,
  output wire [15:0]     SHR_D_O,
  output wire [15:0]     SHR_D_OE,
  input  wire            PAR_READY_IN,
  output reg  [7:0]      PAR_BYTE,
  output reg             PAR_BYTE_VALID,
  output reg             PAR_BYTE_SOS,
  output reg             PAR_BYTE_ERR,
  output reg             PAR_ERR_EVENT,
  output reg  [CD_W-1:0] CD_WORD,
  output reg             CD_WORD_VALID,
  output reg             CD_WORD_RIGHT,
  output reg             CD_WORD_ERR,
  output reg             CD_ERR_EVENT,
  input  wire            ERR_CLR,
  output reg             ERR_SEEN,
  input  wire            CTL_START,
  input  wire [CTL_BITS-1:0] CTL_CMD,
  output wire            CTL_BUSY,
  output reg             CTL_DONE,
  output reg  [CTL_BITS-1:0] CTL_STATUS,
  input  wire            HM_REQ,
  input  wire            HM_WRITE,
  input  wire [1:0]      HM_CS,
  input  wire [2:0]      HM_ADDR,
  input  wire [15:0]     HM_WDATA,
  output wire            HM_BUSY,
  output reg             HM_DONE,
  output reg  [15:0]     HM_RDATA
);

  localparam HS_IDLE = 3'b001;
  localparam HS_STB  = 3'b010;
  localparam HS_WAIT = 3'b100;
  localparam CS_IDLE = 4'b0001;
  localparam CS_RDY  = 4'b0010;
  localparam CS_LOW  = 4'b0100;
  localparam CS_HIGH = 4'b1000;

  function rise;
    input cur;
    input prev;
    begin
      rise = cur & ~prev;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // serial path
  dvdlp_ser_rx #(.BYTE_W(8), .CNT_W(4)) u_ser (
    .clk        (CLK),
    .rst_b      (RST_B),
    .ce         (CE),
    .msb_first  (SER_MSB_FIRST),
    .lclk       (SER_LOADER_CLK),
    .lbit       (SER_LOADER_BIT_IN),
    .lvalid     (SER_LOADER_BIT_VALID),
    .lsos       (SER_SECTOR_START),
    .byte_out   (SER_BYTE),
    .byte_valid (SER_BYTE_VALID),
    .byte_sos   (SER_BYTE_SOS),
    .sos_event  (SER_SOS_EVENT)
  );

  //////////////////////////////////////////////////////////////////////////
  // shared pin synchronisers: {rdy, wr, cs[1:0], d[15:0]}
  reg  [19:0] meta_r;
  reg  [19:0] sync_r;
  reg         stb_d_r;
  reg         bclk_d_r;
  reg         lrck_d_r;
  wire [15:0] s_d    = sync_r[15:0];
  wire        s_sos  = sync_r[16 + `DVDLP_PIN_SOS];
  wire        s_err  = sync_r[16 + `DVDLP_PIN_ERR];
  wire        s_ena  = sync_r[18];
  wire        s_rdy  = sync_r[19];
  wire        s_lrck = s_d[`DVDLP_PIN_CD_CHANNEL_CLK];

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      meta_r   <= 20'h00000;
      sync_r   <= 20'h00000;
      stb_d_r  <= 1'b0;
      bclk_d_r <= 1'b0;
      lrck_d_r <= 1'b0;
    end else if (CE) begin
      meta_r   <= {SHR_RDY_I, SHR_WR_I, SHR_CS_I, SHR_D_I};
      sync_r   <= meta_r;
      stb_d_r  <= s_rdy;
      bclk_d_r <= s_d[`DVDLP_PIN_CD_BIT_CLK];
      lrck_d_r <= s_lrck;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // parallel I/O channel and CD capture
  reg  [CD_W-1:0] cd_sh_r;
  reg             cd_err_r;
  wire            par_take = IOCH_MODE & rise(s_rdy, stb_d_r) & s_ena;
  wire            cd_bit   = IOCH_MODE & rise(s_d[`DVDLP_PIN_CD_BIT_CLK], bclk_d_r);
  wire            cd_word  = IOCH_MODE & (s_lrck ^ lrck_d_r);
  wire            cd_err_w = cd_err_r | (cd_bit & s_d[`DVDLP_PIN_CD_ERR]);

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PAR_BYTE       <= 8'h00;
      PAR_BYTE_VALID <= 1'b0;
      PAR_BYTE_SOS   <= 1'b0;
      PAR_BYTE_ERR   <= 1'b0;
      PAR_ERR_EVENT  <= 1'b0;
      cd_sh_r        <= {CD_W{1'b0}};
      cd_err_r       <= 1'b0;
      CD_WORD        <= {CD_W{1'b0}};
      CD_WORD_VALID  <= 1'b0;
      CD_WORD_RIGHT  <= 1'b0;
      CD_WORD_ERR    <= 1'b0;
      CD_ERR_EVENT   <= 1'b0;
      ERR_SEEN       <= 1'b0;
    end else if (CE) begin
      PAR_BYTE_VALID <= par_take;
      PAR_ERR_EVENT  <= par_take & s_err;
      if (par_take) begin
        PAR_BYTE     <= s_d[7:0];
        PAR_BYTE_SOS <= s_sos;
        PAR_BYTE_ERR <= s_err;
      end
      if (cd_bit) begin
        cd_sh_r <= {cd_sh_r[CD_W-2:0], s_d[`DVDLP_PIN_CD_SERIAL_IN]};
      end
      CD_WORD_VALID <= cd_word;
      CD_ERR_EVENT  <= cd_word & cd_err_w;
      if (cd_word) begin
        CD_WORD       <= cd_sh_r;
        CD_WORD_RIGHT <= lrck_d_r;
        CD_WORD_ERR   <= cd_err_w;
        cd_err_r      <= 1'b0;
      end else begin
        cd_err_r <= cd_err_w;
      end
      // a new error in the clearing cycle keeps the flag set
      if ((par_take & s_err) | (cd_word & cd_err_w)) begin
        ERR_SEEN <= 1'b1;
      end else if (ERR_CLR) begin
        ERR_SEEN <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // loader control port, clock divided from CLK
  reg  [3:0]          cst_r;
  reg  [7:0]          ccnt_r;
  reg  [7:0]          cbit_r;
  reg  [CTL_BITS-1:0] cmd_r;
  reg  [CTL_BITS-1:0] stat_r;
  reg                 ctl_ck_r;
  reg                 ctl_do_r;
  wire                chalf = (ccnt_r == `DVDLP_CTL_HALF_CYC - 1);

  assign CTL_BUSY = ~cst_r[0];

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cst_r      <= CS_IDLE;
      ccnt_r     <= 8'h00;
      cbit_r     <= 8'h00;
      cmd_r      <= {CTL_BITS{1'b0}};
      stat_r     <= {CTL_BITS{1'b0}};
      ctl_ck_r   <= 1'b0;
      ctl_do_r   <= 1'b0;
      CTL_DONE   <= 1'b0;
      CTL_STATUS <= {CTL_BITS{1'b0}};
    end else if (CE) begin
      CTL_DONE <= 1'b0;
      ccnt_r   <= chalf ? 8'h00 : ccnt_r + 8'h01;
      case (cst_r)
        CS_IDLE: begin
          if (CTL_START & IOCH_MODE) begin
            cmd_r  <= CTL_CMD;
            cbit_r <= 8'h00;
            cst_r  <= CS_RDY;
          end
        end
        CS_RDY: begin
          if (s_d[`DVDLP_PIN_CTL_RDY]) begin
            ccnt_r <= 8'h00;
            cst_r  <= CS_LOW;
          end
        end
        CS_LOW: begin
          ctl_ck_r <= 1'b0;
          ctl_do_r <= cmd_r[CTL_BITS-1];
          if (chalf) begin
            ctl_ck_r <= 1'b1;
            cst_r    <= CS_HIGH;
          end
        end
        CS_HIGH: begin
          if (chalf) begin
            ctl_ck_r <= 1'b0;
            stat_r   <= {stat_r[CTL_BITS-2:0], s_d[`DVDLP_PIN_CTL_DI]};
            cmd_r    <= {cmd_r[CTL_BITS-2:0], 1'b0};
            cbit_r   <= cbit_r + 8'h01;
            if (cbit_r == CTL_BITS - 1) begin
              CTL_STATUS <= {stat_r[CTL_BITS-2:0], s_d[`DVDLP_PIN_CTL_DI]};
              CTL_DONE   <= 1'b1;
              cst_r      <= CS_IDLE;
            end else begin
              cst_r <= CS_LOW;
            end
          end
        end
        default: begin
          cst_r <= CS_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // host master: strobe held a least width, then until ready is seen
  reg  [2:0]  hst_r;
  reg  [7:0]  hcnt_r;
  reg         hm_we_r;
  reg         hm_rd_b_r;
  reg         hm_wr_b_r;
  reg  [3:0]  hm_cs_b_r;
  reg  [2:0]  hm_a_r;
  reg  [15:0] hm_wd_r;

  assign HM_BUSY = ~hst_r[0] | IOCH_MODE;

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      hst_r     <= HS_IDLE;
      hcnt_r    <= 8'h00;
      hm_we_r   <= 1'b0;
      hm_rd_b_r <= 1'b1;
      hm_wr_b_r <= 1'b1;
      hm_cs_b_r <= 4'hF;
      hm_a_r    <= 3'h0;
      hm_wd_r   <= 16'h0000;
      HM_DONE   <= 1'b0;
      HM_RDATA  <= 16'h0000;
    end else if (CE) begin
      HM_DONE <= 1'b0;
      case (hst_r)
        HS_IDLE: begin
          if (HM_REQ & ~IOCH_MODE) begin
            hm_we_r   <= HM_WRITE;
            hm_a_r    <= HM_ADDR;
            hm_wd_r   <= HM_WDATA;
            hm_cs_b_r <= ~(4'h1 << HM_CS);
            hm_rd_b_r <= HM_WRITE;
            hm_wr_b_r <= ~HM_WRITE;
            hcnt_r    <= 8'h00;
            hst_r     <= HS_STB;
          end
        end
        HS_STB: begin
          hcnt_r <= hcnt_r + 8'h01;
          if (hcnt_r == `DVDLP_HM_STB_CYC - 1) begin
            hst_r <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (s_rdy) begin
            HM_RDATA  <= hm_we_r ? HM_RDATA : s_d;
            hm_rd_b_r <= 1'b1;
            hm_wr_b_r <= 1'b1;
            hm_cs_b_r <= 4'hF;
            HM_DONE   <= 1'b1;
            hst_r     <= HS_IDLE;
          end
        end
        default: begin
          hst_r <= HS_IDLE;
        end
      endcase
      if (IOCH_MODE) begin
        // mode switch abandons a host cycle so the pins are never shared
        hm_rd_b_r <= 1'b1;
        hm_wr_b_r <= 1'b1;
        hm_cs_b_r <= 4'hF;
        hst_r     <= HS_IDLE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shared pin ownership
  wire [15:0] ioch_oe = (16'h0001 << `DVDLP_PIN_CTL_CK) | (16'h0001 << `DVDLP_PIN_CTL_DO);
  wire [15:0] ioch_do = ({15'h0000, ctl_ck_r} << `DVDLP_PIN_CTL_CK) |
                        ({15'h0000, ctl_do_r} << `DVDLP_PIN_CTL_DO);

  assign SHR_RD_O  = IOCH_MODE ? PAR_READY_IN : hm_rd_b_r;
  assign SHR_WR_O  = hm_wr_b_r;
  assign SHR_WR_OE = ~IOCH_MODE;
  assign SHR_CS_O  = hm_cs_b_r;
  assign SHR_CS_OE = IOCH_MODE ? `DVDLP_CS_OE_IOCH : 4'hF;
  assign SHR_A_O   = hm_a_r;
  assign SHR_D_O   = IOCH_MODE ? ioch_do : hm_wd_r;
  assign SHR_D_OE  = IOCH_MODE ? ioch_oe : {16{~hst_r[0] & hm_we_r}};

endmodule

/* testbench/dvdlp_loader_model.sv */
// loader model: serial sector bits, parallel bytes, control port replies
// assumes its pins reach the data port directly; its timing is its own
`timescale 1ns/100ps

module dvdlp_loader_model (
  input  wire        ctl_clk,
  input  wire        ctl_cmd,
  output reg         ser_clk,
  output reg         ser_bit,
  output reg         ser_vld,
  output reg         ser_sos,
  output reg         par_stb,
  output reg         par_en,
  output reg  [1:0]  par_cs,
  output wire [15:0] d_pins
);
  reg [7:0] par_d;
  reg       ctl_rdy;
  reg [7:0] stat_sr;
  reg [7:0] cmd_seen;
  int       n_rise;
  reg       cd_dat, cd_channel_clk, cd_bit_clk, cd_err;

  // cd bit clock and error lines idle low between words; channel clock toggles once per word
  assign d_pins = {cd_dat, cd_channel_clk, cd_bit_clk, cd_err, stat_sr[7], 1'b0, ctl_rdy, 1'b0,
                   par_d};

  initial begin
    {ser_clk, ser_bit, ser_vld, ser_sos, par_stb, par_en, par_cs} = 8'h00;
    {cd_dat, cd_channel_clk, cd_bit_clk, cd_err} = 4'h0;
    par_d = 8'h00;
    ctl_rdy = 1'b0;
    stat_sr = 8'h81;
    cmd_seen = 8'h00;
    n_rise = 0;
  end

  //////////////////////////////////////////////////////////////////////////
  always @(posedge ctl_clk) begin
    cmd_seen <= {cmd_seen[6:0], ctl_cmd};
    n_rise <= n_rise + 1;
  end
  // moves on the fall so it is settled when sampled at the end of high
  // the x-to-0 settle at time zero is no real clock fall
  always @(negedge ctl_clk) if (n_rise > 0) stat_sr <= {stat_sr[6:0], stat_sr[7]};

  //////////////////////////////////////////////////////////////////////////
  task send_bit(input b, input v, input s);
    ser_bit = b;
    ser_vld = v;
    ser_sos = s;
    #62.5 ser_clk = 1'b1;
    // released in the high phase so the next bit is set alone at the fall
    #30 ser_vld = 1'b0;
    ser_sos = 1'b0;
    // no stale level once the bit has gone
    ser_bit = ~b;
    #32.5 ser_clk = 1'b0;
  endtask

  task send_byte(input [7:0] b, input msb, input sos, input junk);
    int i;
    for (i = 0; i < 8; i++) begin
      send_bit(msb ? b[7-i] : b[i], 1'b1, sos && i == 0);
      if (junk && i == 3) send_bit(~(msb ? b[3] : b[4]), 1'b0, 1'b0);
    end
  endtask

  task par_send(input [7:0] b, input en, input sos, input err);
    par_d = b;
    par_en = en;
    par_cs = {err, sos};
    #40 par_stb = 1'b1;
    #40 par_stb = 1'b0;
    #40 par_en = 1'b0;
    par_cs = 2'b00;
    par_d = ~b;
    #40;
  endtask

  task cd_send(input [15:0] w, input err);
    int i;
    for (i = 15; i >= 0; i--) begin
      cd_dat = w[i];
      cd_err = err && i == 4;
      #40 cd_bit_clk = 1'b1;
      #40 cd_bit_clk = 1'b0;
    end
    cd_err = 1'b0;
    #40 cd_channel_clk = ~cd_channel_clk;
    #40;
  endtask
endmodule

/* testbench/dvdlp_top_chk.sv */
// checker for the loader data port, bound to the top module
// assumes a single CLK domain with RST_B active low
`timescale 1ns/100ps

module dvdlp_top_chk (
  input wire        CLK,
  input wire        RST_B,
  input wire        IOCH_MODE,
  input wire        PAR_READY_IN,
  input wire        SER_LOADER_CLK,
  input wire        SER_SECTOR_START,
  input wire        SHR_WR_I,
  input wire [15:0] SHR_D_I,
  input wire        ERR_CLR,
  input wire        SHR_RD_O,
  input wire        SHR_WR_OE,
  input wire [3:0]  SHR_CS_OE,
  input wire [15:0] SHR_D_O,
  input wire [15:0] SHR_D_OE,
  input wire        HM_BUSY,
  input wire        SER_BYTE_VALID,
  input wire        SER_SOS_EVENT,
  input wire        PAR_BYTE_VALID,
  input wire        PAR_ERR_EVENT,
  input wire        ERR_SEEN,
  input wire        CTL_BUSY
);
  reg [7:0] ctl_hi_r;

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) ctl_hi_r <= 8'h00;
    else if (SHR_D_O[8] && IOCH_MODE) ctl_hi_r <= ctl_hi_r + 8'h01;
    else ctl_hi_r <= 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_busy_unready;
    $rose(CTL_BUSY) && IOCH_MODE && !SHR_D_I[9];
  endsequence
  sequence s_clk_held;
    !SHR_D_O[8] [*4];
  endsequence

  a_rdy_to_loader: assert property (IOCH_MODE |-> SHR_RD_O == PAR_READY_IN)
    else $error("accept-ready not passed to the loader");
  a_pins_exclusive: assert property (IOCH_MODE |-> SHR_CS_OE == 4'hC && !SHR_WR_OE
    && SHR_D_OE == 16'h0500 && HM_BUSY) else $error("host still owns shared pins");
  a_ser_rise_only: assert property (SER_BYTE_VALID |-> $past(SER_LOADER_CLK, 2))
    else $error("serial byte without loader clock rise");
  a_ser_one_pulse: assert property (SER_BYTE_VALID |=> !SER_BYTE_VALID)
    else $error("serial byte valid too long");
  a_sos_level: assert property (SER_SOS_EVENT |-> $past(SER_SECTOR_START, 2))
    else $error("sector start event without high level");
  a_par_enabled: assert property (PAR_BYTE_VALID |-> $past(SHR_WR_I, 2) && $past(IOCH_MODE))
    else $error("parallel byte taken without enable");
  a_ctl_wait_ready: assert property (s_busy_unready |-> s_clk_held)
    else $error("control clock ran before loader ready");
  a_ctl_half_min: assert property ($fell(SHR_D_O[8]) && IOCH_MODE |-> ctl_hi_r >= 8'h32)
    else $error("control clock high phase too short");
  a_ctl_idle_low: assert property (IOCH_MODE && !CTL_BUSY && !$past(CTL_BUSY) |-> !SHR_D_O[8])
    else $error("control clock not idle low");
  a_err_sticky: assert property (PAR_ERR_EVENT || (ERR_SEEN && !ERR_CLR) |=> ERR_SEEN)
    else $error("error flag lost");
endmodule

bind dvdlp_top dvdlp_top_chk i_chk (
  .CLK(CLK), .RST_B(RST_B), .IOCH_MODE(IOCH_MODE), .PAR_READY_IN(PAR_READY_IN),
  .SER_LOADER_CLK(SER_LOADER_CLK), .SER_SECTOR_START(SER_SECTOR_START),
  .SHR_WR_I(SHR_WR_I), .SHR_D_I(SHR_D_I), .ERR_CLR(ERR_CLR), .SHR_RD_O(SHR_RD_O),
  .SHR_WR_OE(SHR_WR_OE), .SHR_CS_OE(SHR_CS_OE), .SHR_D_O(SHR_D_O), .SHR_D_OE(SHR_D_OE),
  .HM_BUSY(HM_BUSY), .SER_BYTE_VALID(SER_BYTE_VALID), .SER_SOS_EVENT(SER_SOS_EVENT),
  .PAR_BYTE_VALID(PAR_BYTE_VALID), .PAR_ERR_EVENT(PAR_ERR_EVENT), .ERR_SEEN(ERR_SEEN),
  .CTL_BUSY(CTL_BUSY)
);

/* testbench/dvdlp_top_test.sv */
// self-checking bench for the loader data port with a loader model
// assumes design, model and checker are compiled ahead of it
`timescale 1ns/100ps

module dvdlp_top_test;
  reg          clk, rst_b, ioch, msb, rdy_in, err_clr, ctl_start, hm_req, hm_write;
  reg   [7:0]  ctl_cmd;
  wire         l_clk, l_bit, l_vld, l_sos, l_stb, l_en;
  wire  [1:0]  l_cs;
  wire  [15:0] l_d, d_o, hm_rdata, cd_word;
  wire  [3:0]  cs_o;
  wire  [7:0]  ser_byte, par_byte, ctl_status;
  wire         ser_vld, ser_sos, sos_ev, rd_o, par_vld, par_sos, par_err, perr_ev;
  wire         err_seen, ctl_busy, ctl_done, hm_done;
  wire         wr_o, cd_vld, cd_right, cd_werr, cd_eev;
  logic [10:0] got_q[$];
  int          n_fail, check_count, sos_n, perr_n, ctl_n, hm_n, cd_n, cd_en;

  dvdlp_loader_model i_ldr (.ctl_clk(d_o[8]), .ctl_cmd(d_o[10]), .ser_clk(l_clk),
    .ser_bit(l_bit), .ser_vld(l_vld), .ser_sos(l_sos), .par_stb(l_stb), .par_en(l_en),
    .par_cs(l_cs), .d_pins(l_d));

  dvdlp_top i_dut (.CLK(clk), .RST_B(rst_b), .CE(1'b1), .IOCH_MODE(ioch),
    .SER_MSB_FIRST(msb), .SER_LOADER_CLK(l_clk), .SER_LOADER_BIT_IN(l_bit),
    .SER_LOADER_BIT_VALID(l_vld), .SER_SECTOR_START(l_sos), .SER_BYTE(ser_byte),
    .SER_BYTE_VALID(ser_vld), .SER_BYTE_SOS(ser_sos), .SER_SOS_EVENT(sos_ev),
    .SHR_RD_O(rd_o), .SHR_WR_I(l_en), .SHR_WR_O(wr_o), .SHR_WR_OE(), .SHR_RDY_I(l_stb),
    .SHR_CS_I(l_cs), .SHR_CS_O(cs_o), .SHR_CS_OE(), .SHR_A_O(), .SHR_D_I(l_d),
    .SHR_D_O(d_o), .SHR_D_OE(), .PAR_READY_IN(rdy_in), .PAR_BYTE(par_byte),
    .PAR_BYTE_VALID(par_vld), .PAR_BYTE_SOS(par_sos), .PAR_BYTE_ERR(par_err),
    .PAR_ERR_EVENT(perr_ev), .CD_WORD(cd_word), .CD_WORD_VALID(cd_vld),
    .CD_WORD_RIGHT(cd_right), .CD_WORD_ERR(cd_werr), .CD_ERR_EVENT(cd_eev),
    .ERR_CLR(err_clr), .ERR_SEEN(err_seen),
    .CTL_START(ctl_start), .CTL_CMD(ctl_cmd), .CTL_BUSY(ctl_busy), .CTL_DONE(ctl_done),
    .CTL_STATUS(ctl_status), .HM_REQ(hm_req), .HM_WRITE(hm_write), .HM_CS(2'h1),
    .HM_ADDR(3'h2), .HM_WDATA(16'h3C5A), .HM_BUSY(), .HM_DONE(hm_done),
    .HM_RDATA(hm_rdata));

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // one queue keeps serial and parallel bytes in arrival order
  always @(posedge clk) begin
    if (ser_vld) got_q.push_back({2'b00, ser_sos, ser_byte});
    if (par_vld) got_q.push_back({1'b1, par_err, par_sos, par_byte});
    if (sos_ev) sos_n++;
    if (perr_ev) perr_n++;
    if (ctl_done) ctl_n++;
    if (hm_done) hm_n++;
    if (cd_vld) cd_n++;
    if (cd_eev) cd_en++;
  end

  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task t_serial;
    int m;
    for (m = 0; m < 2; m++) begin
      msb = m[0];
      step(2);
      i_ldr.send_byte(8'hC5, msb, 1'b1, 1'b1);
      step(8);
      chk(got_q.size(), 1);
      chk(got_q.pop_front(), {2'b00, 1'b1, 8'hC5});
    end
    chk(sos_n, 2);
    $display("t_serial done");
  endtask

  task t_restart;
    int i;
    for (i = 0; i < 5; i++) i_ldr.send_bit(i[0], 1'b1, 1'b0);
    i_ldr.send_byte(8'h96, 1'b1, 1'b1, 1'b0);
    i_ldr.send_byte(8'h3A, 1'b1, 1'b0, 1'b0);
    step(8);
    chk(got_q.size(), 2);
    chk(got_q.pop_front(), {2'b00, 1'b1, 8'h96});
    chk(got_q.pop_front(), {2'b00, 1'b0, 8'h3A});
    $display("t_restart done");
  endtask

  task t_parallel;
    ioch = 1'b1;
    rdy_in = 1'b0;
    step(1);
    chk(rd_o, 1'b0);
    rdy_in = 1'b1;
    step(4);
    chk(rd_o, 1'b1);
    i_ldr.par_send(8'h5A, 1'b1, 1'b1, 1'b0);
    i_ldr.par_send(8'h77, 1'b0, 1'b0, 1'b0);
    i_ldr.par_send(8'hE1, 1'b1, 1'b0, 1'b1);
    step(6);
    chk(got_q.size(), 2);
    chk(got_q.pop_front(), {2'b10, 1'b1, 8'h5A});
    chk(got_q.pop_front(), {2'b11, 1'b0, 8'hE1});
    chk(perr_n, 1);
    chk(err_seen, 1'b1);
    err_clr = 1'b1;
    step(1);
    err_clr = 1'b0;
    step(1);
    chk(err_seen, 1'b0);
    $display("t_parallel done");
  endtask

  task t_cd;
    i_ldr.cd_send(16'hB38D, 1'b0);
    step(6);
    chk(cd_word, 16'hB38D);
    chk({cd_right, cd_werr}, 2'b00);
    i_ldr.cd_send(16'h4E27, 1'b1);
    step(6);
    chk(cd_word, 16'h4E27);
    chk({cd_right, cd_werr, err_seen}, 3'b111);
    chk(cd_n, 2);
    chk(cd_en, 1);
    $display("t_cd done");
  endtask

  task t_host;
    ioch = 1'b0;
    step(4);
    chk(rd_o, 1'b1);
    i_ldr.par_send(8'h11, 1'b1, 1'b0, 1'b0);
    step(6);
    chk(got_q.size(), 0);
    i_ldr.par_d = 8'h96;
    i_ldr.par_stb = 1'b1;
    step(4);
    hm_req = 1'b1;
    step(1);
    hm_req = 1'b0;
    repeat (100) if (hm_n == 0) step(1);
    chk(hm_n, 1);
    chk(hm_rdata, l_d);
    hm_write = 1'b1;
    hm_req = 1'b1;
    step(1);
    hm_req = 1'b0;
    step(1);
    chk({wr_o, cs_o, d_o}, {1'b0, 4'hD, 16'h3C5A});
    repeat (100) if (hm_n == 1) step(1);
    chk({hm_n[7:0], wr_o, cs_o}, {8'h02, 1'b1, 4'hF});
    hm_write = 1'b0;
    i_ldr.par_stb = 1'b0;
    $display("t_host done");
  endtask

  task t_control;
    ioch = 1'b1;
    i_ldr.ctl_rdy = 1'b0;
    step(4);
    ctl_start = 1'b1;
    step(1);
    ctl_start = 1'b0;
    step(150);
    chk(ctl_busy, 1'b1);
    chk(i_ldr.n_rise, 0);
    i_ldr.ctl_rdy = 1'b1;
    repeat (1200) if (ctl_n == 0) step(1);
    chk(ctl_n, 1);
    chk(ctl_status, 8'h81);
    chk(i_ldr.cmd_seen, 8'hA5);
    chk(i_ldr.n_rise, 8);
    $display("t_control done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, ioch, msb, rdy_in, err_clr, ctl_start, hm_req, hm_write} = 8'h00;
    ctl_cmd = 8'hA5;
    step(4);
    rst_b = 1'b1;
    step(4);
    t_serial;
    t_restart;
    t_parallel;
    t_cd;
    t_host;
    t_control;
    end_of_test;
  end

  // whole run is near 19 us; a hang is cut off well beyond that
  initial begin
    #200000;
    n_fail++;
    $display("watchdog expired");
    end_of_test;
  end
endmodule
